// [lift_signal_pkg.sv]
// Shared constants and types for the lift signal output logic.
// Assumes one 40 MHz clock domain and a plain register port.
package lift_signal_pkg;

  localparam int NUM_LANDINGS = 8;
  localparam int DIR_W        = (NUM_LANDINGS - 1) * 2;
  localparam int IDX_W        = 3;
  localparam int GRAY_W       = 3;
  localparam int SER_W        = DIR_W + 2 * NUM_LANDINGS;
  localparam int SER_CNT_W    = 5;

  // Time base for door reversal delay and light cut-out counts
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS  = 100_000_000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  localparam logic [7:0] NUDGE_OFFSET = 8'h96;
  localparam logic [7:0] NUDGE_LIMIT  = 8'hC8;

  // Area start addresses with special meaning
  localparam logic [9:0] ADDR_SEGMENT   = 10'h040;
  localparam logic [9:0] ADDR_CONNECTOR = 10'h039;
  localparam logic [9:0] ADDR_BUS_401   = 10'h191;
  localparam logic [9:0] ADDR_BUS_501   = 10'h1F5;
  localparam logic [9:0] ADDR_BUS_601   = 10'h259;

  // Register offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_REVERSAL  = 8'h04;
  localparam logic [7:0] REG_LIGHT     = 8'h08;
  localparam logic [7:0] REG_DIR_ADDR  = 8'h0C;
  localparam logic [7:0] REG_GONG_ADDR = 8'h10;
  localparam logic [7:0] REG_POS_ADDR  = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;

  // Control field positions
  localparam int CTRL_LIMIT_BIT     = 0;
  localparam int CTRL_TWO_DOORS_BIT = 1;
  localparam int CTRL_GONG_MODE_LSB = 2;
  localparam int CTRL_W             = 4;

  // Reset values
  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam logic [7:0]  REVERSAL_RESET = 8'h00;
  localparam logic [15:0] LIGHT_RESET    = 16'h0BB8;
  localparam logic [9:0]  ADDR_RESET     = 10'h000;

  typedef enum logic [1:0] {
    GONG_ALWAYS,
    GONG_ON_CALL,
    GONG_ON_CALL_DIR
  } gong_mode_type;

  typedef enum logic [1:0] {
    SHIFT_IDLE,
    SHIFT_RUN,
    SHIFT_LATCH
  } shift_state_type;

endpackage

// [serial_link_if.sv]
// Carries an indicator image from the output logic to the serial shifter.
// Assumes both ends share clk.
interface serial_link_if;
  import lift_signal_pkg::*;
  logic             load;
  logic [SER_W-1:0] image;
  logic             sclk;
  logic             sdata;
  logic             latch;
  modport source (output load, output image, input sclk, input sdata, input latch);
  modport shifter (input load, input image, output sclk, output sdata, output latch);
endinterface

// [indicator_shifter.sv]
// Serial shifter feeding an external indicator expansion card.
// Assumes a load pulse only when a new image is to be shown.
module indicator_shifter
  import lift_signal_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  serial_link_if.shifter  link
);
  shift_state_type        state;
  logic [SER_W-1:0]       shreg;
  logic [SER_CNT_W-1:0]   count;

  // Lowest-value bit goes out first; a load while busy restarts the frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= SHIFT_IDLE;
      shreg      <= '0;
      count      <= '0;
      link.sclk  <= 1'b0;
      link.sdata <= 1'b0;
      link.latch <= 1'b0;
    end else begin
      link.latch <= 1'b0;
      if (link.load) begin
        state     <= SHIFT_RUN;
        shreg     <= link.image;
        count     <= '0;
        link.sclk <= 1'b0;
      end else begin
        case (state)
          SHIFT_RUN: begin
            if (!link.sclk) begin
              link.sdata <= shreg[0];
              link.sclk  <= 1'b1;
            end else begin
              link.sclk <= 1'b0;
              shreg     <= shreg >> 1;
              if (count == SER_CNT_W'(SER_W - 1)) begin
                state <= SHIFT_LATCH;
              end else begin
                count <= count + 1'b1;
              end
            end
          end
          SHIFT_LATCH: begin
            link.latch <= 1'b1;
            state      <= SHIFT_IDLE;
          end
          default: state <= SHIFT_IDLE;
        endcase
      end
    end
  end
endmodule

// [lift_signal_output_logic.sv]
// Output-signal logic: door, nudging, light, access side, direction, gong, position.
// Assumes synchronous inputs on clk and a one-cycle register port.
// Functional notes
// - Door-open from limit switch, else safety point three
// - Barrier interrupted inhibits closing; nudging closes slowly
// - Nudging starts after reversal delay minus 150
// - Nudging enabled only between 150 and 200
// - Second door nudging on next output
// - Door-closed signals off while nudging
// - Landing-key output on priority or special service
// - Car light off after cut-out, no call
// - Select served access side on destination travel
// - Direction area is (landings minus 1) times 2
// - Direction outputs set at deceleration start
// - Top landing down arrow at lowest position
// - Addresses 64 or 57 select serial card
// - Bus 401 direction: up line three, down four
// - Second car of pair uses bus 601
// - One gong per landing, fired at deceleration
// - Gong bus 401/501/601 on lines three/four/five
// - Gong modes always, on call, call direction
// - One-hot position, bottom landing lowest
// - One-hot updates on middle sensor plate entry
// - Gray position, least significant bit lowest
// - Gray changes on plate entry or deceleration
//
// Strobed register access and the address map were chosen for this implementation.
module lift_signal_output_logic
  import lift_signal_pkg::*;
#(
  parameter int tick_cycles = TICK_CYCLES
)
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [31:0]             reg_rdata,
  input  wire logic [1:0]              door_open_limit,
  input  wire logic                    safety_circuit_point_three,
  input  wire logic [1:0]              door_closed_switch,
  input  wire logic                    light_barrier,
  input  wire logic                    priority_travel,
  input  wire logic                    landing_special_service,
  input  wire logic                    call_registered,
  input  wire logic                    decel_start,
  input  wire logic                    travel_start,
  input  wire logic [IDX_W-1:0]        dest_landing,
  input  wire logic                    dest_side,
  input  wire logic                    continue_up,
  input  wire logic                    continue_down,
  input  wire logic                    dest_call_up,
  input  wire logic                    dest_call_down,
  input  wire logic                    middle_sensor,
  input  wire logic [IDX_W-1:0]        sensor_landing,
  output logic      [1:0]              door_open,
  output logic                         doors_open_any,
  output logic      [1:0]              nudge,
  output logic      [1:0]              door_closed,
  output logic                         close_inhibit,
  output logic                         close_slow,
  output logic                         landing_key_travel,
  output logic                         light_off_relay,
  output logic      [1:0]              access_side,
  output logic      [DIR_W-1:0]        direction_area,
  output logic      [NUM_LANDINGS-1:0] gong_area,
  output logic      [NUM_LANDINGS-1:0] position_area,
  output logic      [GRAY_W-1:0]       gray_position,
  output logic      [NUM_LANDINGS-1:0] bus_module_line_three,
  output logic      [NUM_LANDINGS-1:0] bus_module_line_four,
  output logic      [NUM_LANDINGS-1:0] bus_module_line_five,
  output logic      [NUM_LANDINGS-1:0] pair_line_three,
  output logic      [NUM_LANDINGS-1:0] pair_line_four,
  output logic                         serial_clk,
  output logic                         serial_data,
  output logic                         serial_latch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  serial_link_if link ();

  logic [CTRL_W-1:0]       ctrl;
  logic [7:0]              reversal;
  logic [15:0]             light_cutout;
  logic [9:0]              dir_addr;
  logic [9:0]              gong_addr;
  logic [9:0]              pos_addr;
  logic [31:0]             tick_count;
  logic                    tick;
  logic [7:0]              nudge_count;
  logic [15:0]             light_count;
  logic                    sensor_prev;
  logic [IDX_W-1:0]        car_index;
  logic [DIR_W-1:0]        dir_image;
  logic [NUM_LANDINGS-1:0] gong_image;
  logic [NUM_LANDINGS-1:0] pos_image;
  logic                    images_changed;
  logic                    nudge_enabled;
  logic [7:0]              nudge_thresh;
  logic                    sensor_entry;
  logic                    gong_fire;
  logic [NUM_LANDINGS-1:0] dir_up_bits;
  logic [NUM_LANDINGS-1:0] dir_down_bits;
  logic [31:0]             next_rdata;

  function automatic logic is_serial(input logic [9:0] a);
    return (a == ADDR_SEGMENT) || (a == ADDR_CONNECTOR);
  endfunction

  function automatic logic is_bus(input logic [9:0] a);
    return a >= ADDR_BUS_401;
  endfunction

  // Up arrow of landing k at 2k+1, down arrow at 2k, top down arrow at 0
  function automatic logic [DIR_W-1:0] dir_bit(input logic [IDX_W-1:0] k, input logic up);
    logic [DIR_W-1:0] v;
    v = '0;
    if (up && (int'(k) < NUM_LANDINGS - 1)) begin
      v[2 * int'(k) + 1] = 1'b1;
    end else if (!up && (int'(k) == NUM_LANDINGS - 1)) begin
      v[0] = 1'b1;
    end else if (!up && (k != '0)) begin
      v[2 * int'(k)] = 1'b1;
    end
    return v;
  endfunction

  assign nudge_enabled = (reversal > NUDGE_OFFSET) && (reversal < NUDGE_LIMIT);
  assign nudge_thresh  = reversal - NUDGE_OFFSET;
  assign sensor_entry  = middle_sensor && !sensor_prev;

  always_comb begin
    case (gong_mode_type'(ctrl[CTRL_GONG_MODE_LSB +: 2]))
      GONG_ALWAYS:      gong_fire = 1'b1;
      GONG_ON_CALL:     gong_fire = dest_call_up || dest_call_down;
      GONG_ON_CALL_DIR: gong_fire = (continue_up && dest_call_up) ||
                                    (continue_down && dest_call_down);
      default:          gong_fire = 1'b0;
    endcase
  end

  // Register port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl         <= CTRL_RESET;
      reversal     <= REVERSAL_RESET;
      light_cutout <= LIGHT_RESET;
      dir_addr     <= ADDR_RESET;
      gong_addr    <= ADDR_RESET;
      pos_addr     <= ADDR_RESET;
    end else if (reg_write) begin
      case (reg_addr)
        REG_CTRL:      ctrl         <= reg_wdata[CTRL_W-1:0];
        REG_REVERSAL:  reversal     <= reg_wdata[7:0];
        REG_LIGHT:     light_cutout <= reg_wdata[15:0];
        REG_DIR_ADDR:  dir_addr     <= reg_wdata[9:0];
        REG_GONG_ADDR: gong_addr    <= reg_wdata[9:0];
        REG_POS_ADDR:  pos_addr     <= reg_wdata[9:0];
        default:       ctrl         <= ctrl;
      endcase
    end
  end

  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      REG_CTRL:      next_rdata[CTRL_W-1:0] = ctrl;
      REG_REVERSAL:  next_rdata[7:0]        = reversal;
      REG_LIGHT:     next_rdata[15:0]       = light_cutout;
      REG_DIR_ADDR:  next_rdata[9:0]        = dir_addr;
      REG_GONG_ADDR: next_rdata[9:0]        = gong_addr;
      REG_POS_ADDR:  next_rdata[9:0]        = pos_addr;
      REG_STATUS:    next_rdata[11:0]       = {gray_position, car_index, light_off_relay,
                                               nudge[0], nudge_enabled, light_barrier,
                                               1'b0, 1'b0};
      default:       next_rdata             = '0;
    endcase
  end

  // Read data valid only in the cycle after the read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : '0;
    end
  end

  // Time base
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else begin
      tick       <= (tick_count == 32'(tick_cycles - 1));
      tick_count <= (tick_count == 32'(tick_cycles - 1)) ? '0 : tick_count + 1'b1;
    end
  end

  // Doors and nudging
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      door_open      <= '0;
      doors_open_any <= 1'b0;
      nudge_count    <= '0;
      nudge          <= '0;
      door_closed    <= '0;
      close_inhibit  <= 1'b0;
      close_slow     <= 1'b0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        door_open[d] <= ctrl[CTRL_LIMIT_BIT] ? door_open_limit[d]
                                             : safety_circuit_point_three;
      end
      doors_open_any <= ctrl[CTRL_LIMIT_BIT] ? |door_open_limit
                                             : safety_circuit_point_three;
      if (!light_barrier) begin
        nudge_count <= '0;
      end else if (tick && nudge_count != 8'hFF) begin
        nudge_count <= nudge_count + 1'b1;
      end
      nudge[0] <= nudge_enabled && light_barrier && (nudge_count >= nudge_thresh);
      // Second operator uses the next output only when fitted
      nudge[1] <= ctrl[CTRL_TWO_DOORS_BIT] && nudge_enabled && light_barrier &&
                  (nudge_count >= nudge_thresh);
      door_closed   <= door_closed_switch & {2{!(nudge_enabled && light_barrier &&
                       (nudge_count >= nudge_thresh))}};
      close_inhibit <= light_barrier && !(nudge_enabled &&
                       (nudge_count >= nudge_thresh));
      close_slow    <= light_barrier && nudge_enabled &&
                       (nudge_count >= nudge_thresh);
    end
  end

  // Status and car light
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      landing_key_travel <= 1'b0;
      light_count        <= '0;
      light_off_relay    <= 1'b0;
    end else begin
      landing_key_travel <= priority_travel || landing_special_service;
      if (call_registered) begin
        light_count <= '0;
      end else if (tick && light_count != 16'hFFFF) begin
        light_count <= light_count + 1'b1;
      end
      light_off_relay <= !call_registered && (light_count >= light_cutout);
    end
  end

  // Arrival images; cleared when the next travel starts
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      access_side <= '0;
      dir_image   <= '0;
      gong_image  <= '0;
    end else if (travel_start) begin
      access_side <= '0;
      dir_image   <= '0;
      gong_image  <= '0;
    end else if (decel_start) begin
      access_side <= dest_side ? 2'h2 : 2'h1;
      dir_image   <= (continue_up   ? dir_bit(dest_landing, 1'b1) : '0) |
                     (continue_down ? dir_bit(dest_landing, 1'b0) : '0);
      gong_image  <= gong_fire ? NUM_LANDINGS'(1) << dest_landing : '0;
    end
  end

  // Car position
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sensor_prev <= 1'b0;
      car_index   <= '0;
      pos_image   <= NUM_LANDINGS'(1);
      gray_position <= '0;
    end else begin
      sensor_prev <= middle_sensor;
      if (sensor_entry) begin
        car_index     <= sensor_landing;
        pos_image     <= NUM_LANDINGS'(1) << sensor_landing;
        gray_position <= sensor_landing ^ (sensor_landing >> 1);
      end else if (decel_start) begin
        gray_position <= dest_landing ^ (dest_landing >> 1);
      end
    end
  end

  // Up and down arrows per landing for the bus mapping
  // Loop bounds keep every index inside the direction image
  always_comb begin
    dir_up_bits   = '0;
    dir_down_bits = '0;
    for (int k = 0; k < NUM_LANDINGS - 1; k++) begin
      dir_up_bits[k] = dir_image[2 * k + 1];
    end
    for (int k = 1; k < NUM_LANDINGS - 1; k++) begin
      dir_down_bits[k] = dir_image[2 * k];
    end
    dir_down_bits[NUM_LANDINGS-1] = dir_image[0];
  end

  // Area routing: parallel, serial card or landing bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      direction_area        <= '0;
      gong_area             <= '0;
      position_area         <= '0;
      bus_module_line_three <= '0;
      bus_module_line_four  <= '0;
      bus_module_line_five  <= '0;
      pair_line_three       <= '0;
      pair_line_four        <= '0;
    end else begin
      direction_area <= (dir_addr == '0 || is_serial(dir_addr) || is_bus(dir_addr))
                        ? '0 : dir_image;
      gong_area      <= (gong_addr == '0 || is_serial(gong_addr) || is_bus(gong_addr))
                        ? '0 : gong_image;
      position_area  <= (pos_addr == '0 || is_serial(pos_addr)) ? '0 : pos_image;
      bus_module_line_three <= ((dir_addr == ADDR_BUS_401) ? dir_up_bits : '0) |
                               ((gong_addr == ADDR_BUS_401) ? gong_image : '0);
      bus_module_line_four  <= ((dir_addr == ADDR_BUS_401) ? dir_down_bits : '0) |
                               ((gong_addr == ADDR_BUS_501) ? gong_image : '0);
      bus_module_line_five  <= (gong_addr == ADDR_BUS_601) ? gong_image : '0;
      // This controller drives the second car's arrows of a pair
      pair_line_three <= (dir_addr == ADDR_BUS_601) ? dir_up_bits : '0;
      pair_line_four  <= (dir_addr == ADDR_BUS_601) ? dir_down_bits : '0;
    end
  end

  // Serial image; only streams addressed to the card are shifted
  assign link.image = {is_serial(pos_addr) ? pos_image : NUM_LANDINGS'(0),
                       is_serial(gong_addr) ? gong_image : NUM_LANDINGS'(0),
                       is_serial(dir_addr) ? dir_image : DIR_W'(0)};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      images_changed <= 1'b0;
      link.load      <= 1'b0;
    end else begin
      images_changed <= decel_start || travel_start || sensor_entry;
      link.load      <= images_changed &&
                        (is_serial(dir_addr) || is_serial(gong_addr) || is_serial(pos_addr));
    end
  end

  indicator_shifter u_shifter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .link    (link.shifter)
  );

  assign serial_clk   = link.sclk;
  assign serial_data  = link.sdata;
  assign serial_latch = link.latch;

  sequence seq_decel;
    decel_start && !travel_start;
  endsequence

  sequence seq_nudging;
    light_barrier && nudge_enabled && (nudge_count >= nudge_thresh);
  endsequence

  a_door_open_source: assert property (
    ctrl[CTRL_LIMIT_BIT] == 1'b0 ##1 1'b1 |-> doors_open_any == $past(safety_circuit_point_three)
  ) else $error("door open not following safety point");

  a_nudge_window: assert property (
    nudge[0] |-> $past(reversal) > NUDGE_OFFSET && $past(reversal) < NUDGE_LIMIT
  ) else $error("nudging outside enabled window");

  a_nudge_delay: assert property (
    $rose(nudge[0]) |-> $past(nudge_count) >= $past(nudge_thresh)
  ) else $error("nudging started early");

  a_closed_gated: assert property (
    seq_nudging |=> door_closed == 2'h0 && close_slow && !close_inhibit
  ) else $error("door closed shown during nudging");

  a_key_travel: assert property (
    (priority_travel || landing_special_service) |=> landing_key_travel
  ) else $error("landing key output missing");

  a_side_select: assert property (
    seq_decel |=> access_side == ($past(dest_side) ? 2'h2 : 2'h1)
  ) else $error("wrong access side");

  a_gong_decel: assert property (
    seq_decel ##0 gong_fire |=> gong_image[$past(dest_landing)] ##1 1'b1
  ) else $error("gong not fired at deceleration");

  a_onehot_pos: assert property (
    sensor_entry |=> $onehot(pos_image) && pos_image[$past(sensor_landing)]
  ) else $error("position not one-hot on plate entry");

  a_gray_code: assert property (
    sensor_entry |=> gray_position == ($past(sensor_landing) ^ ($past(sensor_landing) >> 1))
  ) else $error("gray position wrong");

endmodule

// [indicator_card.sv]
// Expansion card model: shifts the serial image in, shows it on latch.
// Assumes data settle before the falling edge of the serial clock.
module indicator_card
  import lift_signal_pkg::*;
(
  input  wire logic             sys_rst,
  input  wire logic             serial_clk,
  input  wire logic             serial_data,
  input  wire logic             serial_latch,
  output logic      [SER_W-1:0] shown
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [SER_W-1:0] shift;
  // Sample mid-bit, away from the edge where the data move
  always_ff @(negedge serial_clk or posedge sys_rst)
    if (sys_rst) shift <= '0;
    else shift <= {serial_data, shift[SER_W-1:1]};
  always_ff @(posedge serial_latch or posedge sys_rst)
    if (sys_rst) shown <= '0;
    else shown <= shift;
endmodule

// [test_lift_signal_output_logic.sv]
// Bench for the lift signal output logic and an expansion card model.
// Assumes the one-cycle register port and a tick of 4 clocks.
module test_lift_signal_output_logic
  import lift_signal_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, light_barrier = 0;
  logic safety_circuit_point_three = 0, priority_travel = 0, landing_special_service = 0;
  logic call_registered = 0, decel_start = 0, travel_start = 0, dest_side = 0;
  logic continue_up = 0, continue_down = 0, dest_call_up = 0, dest_call_down = 0;
  logic middle_sensor = 0, close_inhibit, close_slow, landing_key_travel, light_off_relay;
  logic serial_clk, serial_data, serial_latch, doors_open_any;
  logic [NUM_LANDINGS-1:0] pair_line_three, pair_line_four;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [1:0] door_open_limit = 0, door_closed_switch = 0, door_open, nudge;
  logic [1:0] door_closed, access_side;
  logic [IDX_W-1:0] dest_landing = 0, sensor_landing = 0;
  logic [GRAY_W-1:0] gray_position;
  logic [DIR_W-1:0] direction_area;
  logic [NUM_LANDINGS-1:0] gong_area, position_area, bus_module_line_three;
  logic [NUM_LANDINGS-1:0] bus_module_line_four, bus_module_line_five;
  logic [SER_W-1:0] card_image;
  int n_mismatch = 0, checks_done = 0, cycles = 0;

  lift_signal_output_logic #(.tick_cycles(4)) i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .door_open_limit, .safety_circuit_point_three,
    .door_closed_switch, .light_barrier, .priority_travel, .landing_special_service,
    .call_registered, .decel_start, .travel_start, .dest_landing, .dest_side, .continue_up,
    .continue_down, .dest_call_up, .dest_call_down, .middle_sensor, .sensor_landing,
    .door_open, .doors_open_any, .nudge, .door_closed, .close_inhibit, .close_slow,
    .landing_key_travel, .light_off_relay, .access_side, .direction_area, .gong_area,
    .position_area, .gray_position, .bus_module_line_three, .bus_module_line_four,
    .bus_module_line_five, .pair_line_three, .pair_line_four, .serial_clk,
    .serial_data, .serial_latch);
  indicator_card i_card (.sys_rst, .serial_clk, .serial_data, .serial_latch,
    .shown(card_image));

  initial forever #12.5 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard, well above the fewer than a thousand cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Strobe drops with a gap edge so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
    @(posedge clk);
  endtask

  task automatic arrive(input logic [2:0] d, input logic u, input logic cd);
    dest_landing <= d;
    continue_up <= u;
    continue_down <= ~u;
    dest_call_down <= cd;
    decel_start <= 1'b1;
    @(posedge clk);
    decel_start <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic leave();
    @(posedge clk);
    travel_start <= 1'b1;
    @(posedge clk);
    travel_start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_misc();
    wr(REG_CTRL, 32'h3);
    safety_circuit_point_three <= 1'b1;
    door_open_limit <= 2'h1;
    priority_travel <= 1'b1;
    repeat (2) @(negedge clk);
    check(door_open, 2'h1);
    check(landing_key_travel, 1'b1);
    @(posedge clk);
    priority_travel <= 1'b0;
    landing_special_service <= 1'b1;
    wr(REG_CTRL, 32'h2);
    wr(REG_LIGHT, 32'h2);
    repeat (20) @(negedge clk);
    check(door_open, 2'h3);
    check(landing_key_travel, 1'b1);
    check(light_off_relay, 1'b1);
    @(posedge clk);
    call_registered <= 1'b1;
    safety_circuit_point_three <= 1'b0;
    repeat (3) @(negedge clk);
    check(light_off_relay, 1'b0);
    check(doors_open_any, 1'b0);
    @(posedge clk);
    call_registered <= 1'b0;
    repeat (4) @(negedge clk);
    check(light_off_relay, 1'b0);
    repeat (12) @(negedge clk);
    check(light_off_relay, 1'b1);
    @(posedge clk);
  endtask

  task automatic t_nudge();
    wr(REG_REVERSAL, 32'hAF);
    door_closed_switch <= 2'h3;
    light_barrier <= 1'b1;
    repeat (80) @(negedge clk);
    check(nudge, 2'h0);
    check(door_closed, 2'h3);
    for (int n = 0; n < 40 && nudge !== 2'h3; n++) @(negedge clk);
    check(nudge, 2'h3);
    check(door_closed, 2'h0);
    check(close_slow, 1'b1);
    @(posedge clk);
    light_barrier <= 1'b0;
    wr(REG_REVERSAL, 32'hC8);
    light_barrier <= 1'b1;
    repeat (250) @(negedge clk);
    check(nudge, 2'h0);
    check(close_inhibit, 1'b1);
    @(posedge clk);
    light_barrier <= 1'b0;
  endtask

  task automatic t_arrival();
    wr(REG_DIR_ADDR, 32'h10);
    wr(REG_GONG_ADDR, 32'h20);
    dest_side <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      wr(REG_CTRL, m << 2);
      arrive(3'h3, 1'b1, 1'b1);
      check(access_side, 2'h2);
      check(gray_position, 3'h2);
      check(direction_area, 14'h0080);
      check(gong_area, m < 2 ? 8'h08 : 8'h00);
      leave();
    end
    arrive(3'h7, 1'b0, 1'b1);
    check(direction_area, 14'h0001);
    check(gong_area, 8'h80);
    leave();
    wr(REG_DIR_ADDR, {22'h0, ADDR_BUS_401});
    wr(REG_GONG_ADDR, {22'h0, ADDR_BUS_601});
    wr(REG_CTRL, 32'h0);
    arrive(3'h2, 1'b0, 1'b0);
    check(bus_module_line_four, 8'h04);
    check(bus_module_line_five, 8'h04);
    leave();
    wr(REG_DIR_ADDR, {22'h0, ADDR_BUS_601});
    wr(REG_GONG_ADDR, {22'h0, ADDR_BUS_401});
    arrive(3'h2, 1'b0, 1'b0);
    check(pair_line_four, 8'h04);
    check(pair_line_three, 8'h00);
    check(bus_module_line_three, 8'h04);
    leave();
  endtask

  task automatic t_serial();
    logic [9:0] a[2] = '{ADDR_SEGMENT, ADDR_CONNECTOR};
    wr(REG_GONG_ADDR, 32'h0);
    foreach (a[i]) begin
      wr(REG_DIR_ADDR, {22'h0, a[i]});
      arrive(3'h3, 1'b1, 1'b0);
      for (int n = 0; n < 200 && card_image[13:0] !== 14'h0080; n++) @(negedge clk);
      check(card_image[13:0], 14'h0080);
      leave();
      repeat (100) @(negedge clk);
      check(card_image[13:0], 14'h0);
      @(posedge clk);
    end
  endtask

  task automatic t_pos();
    wr(REG_POS_ADDR, 32'h30);
    sensor_landing <= 3'h5;
    middle_sensor <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(gray_position, 3'h7);
    @(negedge clk);
    check(position_area, 8'h20);
    @(posedge clk);
    middle_sensor <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(REG_LIGHT, 32'h0BB8);
    rd(8'hFC, 32'h0);
    $display("registers done");
    t_misc();
    $display("misc done");
    t_nudge();
    $display("nudge done");
    t_arrival();
    $display("arrival done");
    t_serial();
    $display("serial done");
    t_pos();
    $display("position done");
    report_and_stop();
  end
endmodule
